// ===== hw/frsr_rate_decode.sv
// data rate, density and drive density pin decode
`timescale 1ns/10ps
`default_nettype none
module frsr_rate_decode
  import frsr_pkg::*;
(
  // selection
  input wire logic [1:0] rateCode,
  input wire logic [1:0] driveRateType,
  input wire logic [1:0] driveTypeCode,
  input wire logic fmMode,
  // results
  output frsr_rate_type rateSel,
  output logic [11:0] dataRateKbps,
  output logic densitySelect,
  output logic [1:0] driveDensityPins
);
  // rate from select code and drive rate type
  always_comb begin
    case (rateCode)
      2'b11: rateSel = RATE_1M;
      2'b00: rateSel = RATE_500;
      2'b01: begin
        case (driveRateType)
          2'b01: rateSel = RATE_500;
          2'b10: rateSel = RATE_2M;
          default: rateSel = RATE_300;
        endcase
      end
      default: rateSel = RATE_250;
    endcase
  end

  // kbps, fm at half for the low rates
  always_comb begin
    case (rateSel)
      RATE_2M: dataRateKbps = 12'h7D0;
      RATE_1M: dataRateKbps = 12'h3E8;
      RATE_500: dataRateKbps = fmMode ? 12'h0FA : 12'h1F4;
      RATE_300: dataRateKbps = fmMode ? 12'h096 : 12'h12C;
      default: dataRateKbps = fmMode ? 12'h07D : 12'h0FA;
    endcase
  end

  // density high for codes 11 and 00 only
  assign densitySelect = (rateCode == 2'b11) || (rateCode == 2'b00);

  // pin mapping by drive type
  always_comb begin
    case (driveTypeCode)
      2'b00: driveDensityPins = {rateCode[0], densitySelect};
      2'b10: driveDensityPins = {rateCode[0], rateCode[1]};
      2'b01: driveDensityPins = {rateCode[0], ~densitySelect};
      default: driveDensityPins = {rateCode[1], rateCode[0]};
    endcase
  end
endmodule : frsr_rate_decode
`default_nettype wire

// ===== hw/frsr_regs.sv
// host registers for tape drive, rate select and main status
`timescale 1ns/10ps
`default_nettype none
module frsr_regs
  import frsr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // host io port
  input wire logic [15:0] ioAddr,
  input wire logic ioRdStrobe,
  input wire logic ioWrStrobe,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  // configuration
  input wire logic enhancedMode2,
  input wire logic [7:0] floppyConfigF1,
  input wire logic [7:0] floppyConfigF2,
  input wire logic [1:0] driveRateType,
  input wire logic [1:0] driveSelect,
  input wire logic dorSoftResetN,
  // media pins
  input wire logic [1:0] mediaIdentPins,
  // command engine status
  input wire logic [3:0] driveSeekBusy,
  input wire logic cmdBusy,
  input wire logic polledExecFlag,
  input wire logic transferDirection,
  input wire logic requestForMaster,
  input wire logic fmMode,
  input wire logic [7:0] currentTrack,
  input wire logic [7:0] precompStartTrack,
  // controller outputs
  output logic ctrlSoftReset,
  output logic ctrlClockStop,
  output logic [1:0] rateCode,
  output frsr_rate_type rateSel,
  output logic [11:0] dataRateKbps,
  output logic densitySelect,
  output logic [1:0] driveDensityPins,
  output logic [3:0] writePrecompUnits,
  output logic precompEnable,
  output logic [7:0] dsrShadow,
  output logic dataRegGrant
);

  // port hit on a given address
  function automatic logic portHit(input logic [15:0] a,
                                   input logic [15:0] p);
    portHit = (a == p);
  endfunction : portHit

  logic wrRate;
  logic wrCcr;
  logic wrTape;
  logic rdStatus;
  logic rdTape;
  logic dataAccess;
  logic [1:0] mediaMeta_q;
  logic [1:0] mediaSync_q;
  logic [1:0] tapeSel_q;
  logic [1:0] rateCode_q;
  logic [2:0] writeCodeA_q;
  logic resvBit_q;
  logic lowPower_q;
  logic [3:0] swRstCnt_q;
  logic [3:0] swRstCnt_d;
  logic [7:0] rdData_q;
  logic [7:0] tapeView;
  logic [7:0] mainStatus;
  logic [1:0] driveTypeCode;
  logic [3:0] write_code_a_d;
  logic [3:0] write_code_a_q;

  // strobe decode
  assign wrRate = ioWrStrobe && portHit(ioAddr, ADDR_RATE_STAT);
  assign wrCcr = ioWrStrobe && portHit(ioAddr, ADDR_CCR);
  assign wrTape = ioWrStrobe && portHit(ioAddr, ADDR_TAPE);
  assign rdStatus = ioRdStrobe && portHit(ioAddr, ADDR_RATE_STAT);
  assign rdTape = ioRdStrobe && portHit(ioAddr, ADDR_TAPE);
  assign dataAccess = (ioRdStrobe || ioWrStrobe) && portHit(ioAddr, ADDR_DATA);

  // media pin synchronisers, never reset
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gMediaSync
      always_ff @(posedge ref_clk) begin
        mediaMeta_q[gi] <= mediaIdentPins[gi];
        mediaSync_q[gi] <= mediaMeta_q[gi];
      end
    end
  endgenerate

  // tape select bits, hardware reset only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tapeSel_q <= TAPE_RESET;
    end else if (wrTape) begin
      tapeSel_q <= ioWrData[1:0];
    end
  end

  // drive type pair chosen by selected drive
  always_comb begin
    case (driveSelect)
      2'b00: driveTypeCode = floppyConfigF2[1:0];
      2'b01: driveTypeCode = floppyConfigF2[3:2];
      2'b10: driveTypeCode = floppyConfigF2[5:4];
      default: driveTypeCode = floppyConfigF2[7:6];
    endcase
  end

  // tape drive register read view
  always_comb begin
    tapeView = 8'h00;
    tapeView[1:0] = tapeSel_q;
    if (enhancedMode2) begin
      tapeView[TDR_MEDIA1_BIT] = mediaSync_q[1] ^ floppyConfigF1[F1_INV1];
      tapeView[TDR_MEDIA0_BIT] = mediaSync_q[0] ^ floppyConfigF1[F1_INV0];
      tapeView[TDR_TYPE_LSB+:2] = driveTypeCode;
      tapeView[TDR_BOOT_LSB+1] = floppyConfigF1[F1_BOOT_HI];
      tapeView[TDR_BOOT_LSB] = floppyConfigF1[F1_BOOT_LO];
    end
  end

  // main status, composed live
  assign mainStatus = {requestForMaster,
                       transferDirection,
                       polledExecFlag,
                       cmdBusy,
                       driveSeekBusy};

  // data register access allowed only with request set
  assign dataRegGrant = requestForMaster;

  // shared rate code, last writer wins
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rateCode_q <= DSR_RESET[DSR_RATE_LSB+:2];
    end else if (wrRate) begin
      rateCode_q <= ioWrData[DSR_RATE_LSB+:2];
    end else if (wrCcr) begin
      rateCode_q <= ioWrData[1:0];
    end
  end

  // precompensation and reserved bits of the rate select register, soft reset leaves them
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      writeCodeA_q <= DSR_RESET[DSR_PRE_LSB+:3];
      resvBit_q <= DSR_RESET[DSR_RSVD_BIT];
    end else if (wrRate) begin
      writeCodeA_q <= ioWrData[DSR_PRE_LSB+:3];
      resvBit_q <= ioWrData[DSR_RSVD_BIT];
    end
  end

  // self clearing soft reset stretch
  always_comb begin
    swRstCnt_d = swRstCnt_q;
    if (wrRate && ioWrData[DSR_SWRST_BIT]) begin
      swRstCnt_d = SW_RESET_CYCLES;
    end else if (swRstCnt_q != 4'h0) begin
      swRstCnt_d = swRstCnt_q - 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      swRstCnt_q <= 4'h0;
    end else begin
      swRstCnt_q <= swRstCnt_d;
    end
  end

  // either reset source stops the controller
  assign ctrlSoftReset = (swRstCnt_q != 4'h0) || !dorSoftResetN;

  // manual low power, set beats exit
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lowPower_q <= 1'b0;
    end else if (wrRate && ioWrData[DSR_LOWPWR_BIT]) begin
      lowPower_q <= 1'b1;
    end else if (ctrlSoftReset || rdStatus || dataAccess) begin
      lowPower_q <= 1'b0;
    end
  end

  assign ctrlClockStop = lowPower_q;

  // registered read data
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdData_q <= 8'h00;
    end else if (rdStatus) begin
      rdData_q <= mainStatus;
    end else if (rdTape) begin
      rdData_q <= tapeView;
    end else if (ioRdStrobe) begin
      rdData_q <= 8'h00;
    end
  end

  assign ioRdData = rdData_q;

  // rate, density and pins
  frsr_rate_decode uDecode (
    .rateCode(rateCode_q),
    .driveRateType(driveRateType),
    .driveTypeCode(driveTypeCode),
    .fmMode(fmMode),
    .rateSel(rateSel),
    .dataRateKbps(dataRateKbps),
    .densitySelect(densitySelect),
    .driveDensityPins(driveDensityPins)
  );

  // precompensation delay in 1/48 MHz units
  always_comb begin
    write_code_a_d = {1'b0, writeCodeA_q};
    if (writeCodeA_q == PRE_ZERO) begin
      write_code_a_d = 4'h0;
    end else if (writeCodeA_q == PRE_DEFAULT) begin
      case (rateSel)
        RATE_2M: write_code_a_d = PRE_DEF_2M;
        RATE_1M: write_code_a_d = PRE_DEF_1M;
        default: write_code_a_d = PRE_DEF_LOW;
      endcase
    end else if (rateSel != RATE_2M) begin
      write_code_a_d = {writeCodeA_q, 1'b0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      write_code_a_q <= PRE_DEF_LOW;
    end else begin
      write_code_a_q <= write_code_a_d;
    end
  end

  assign writePrecompUnits = write_code_a_q;

  // write_code_a only from the start track outward
  assign precompEnable = (currentTrack >= precompStartTrack);

  // shadow copy of the rate select register
  assign dsrShadow = {swRstCnt_q != 4'h0, lowPower_q, resvBit_q, writeCodeA_q, rateCode_q};
  assign rateCode = rateCode_q;

  // checks
  sequence sRstHigh;
    ctrlSoftReset [*8];
  endsequence

  sequence sRstEnd;
    ##[1:4] (swRstCnt_q == 4'h0);
  endsequence

  AST_MEDIA_BITS: assert property (@(posedge ref_clk) disable iff (!resetn)
    rdTape && enhancedMode2 |=>
      ioRdData[7:6] == ($past(mediaSync_q) ^ $past(floppyConfigF1[5:4])))
    else $error("media_ident_pins bits wrong");

  AST_DRIVE_TYPE: assert property (@(posedge ref_clk) disable iff (!resetn)
    rdTape && enhancedMode2 && driveSelect == 2'b11 |=>
      ioRdData[5:4] == $past(floppyConfigF2[7:6]))
    else $error("drive type field wrong");

  AST_BOOT_BITS: assert property (@(posedge ref_clk) disable iff (!resetn)
    rdTape && enhancedMode2 |=>
      ioRdData[3:2] == $past(floppyConfigF1[7:6]) && ioRdData[1:0] == $past(tapeSel_q))
    else $error("boot drive field wrong");

  AST_HW_RESET: assert property (@(posedge ref_clk)
    !resetn |=> rateCode_q == 2'b10 && writeCodeA_q == 3'h0 && !lowPower_q)
    else $error("rate select reset value wrong");

  AST_RATE_LAST: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrCcr && !wrRate |=> rateCode_q == $past(ioWrData[1:0]))
    else $error("ccr write did not set rate");

  AST_SW_RESET: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrRate && ioWrData[7] |=> sRstHigh ##0 sRstEnd)
    else $error("soft reset pulse length wrong");

  AST_LOW_POWER_EXIT: assert property (@(posedge ref_clk) disable iff (!resetn)
    (rdStatus || dataAccess) && !wrRate |=> !ctrlClockStop)
    else $error("low power not left on access");

  AST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (!resetn)
    rdStatus |=> ioRdData == $past(mainStatus))
    else $error("main status read wrong");

  AST_DEFAULT_WRITE_CODE_A: assert property (@(posedge ref_clk) disable iff (!resetn)
    writeCodeA_q == 3'h0 && rateSel == RATE_1M |=> writePrecompUnits == 4'h2)
    else $error("default write_code_a wrong at 1M");

  AST_DENSITY: assert property (@(posedge ref_clk) disable iff (!resetn)
    densitySelect == (rateCode_q[0] == rateCode_q[1]))
    else $error("density select wrong");

  AST_TAPE_PLAIN: assert property (@(posedge ref_clk) disable iff (!resetn)
    rdTape && !enhancedMode2 |=> ioRdData == {6'h00, $past(tapeSel_q)})
    else $error("plain tape view wrong");

  AST_RATE_DSR: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrRate |=> rateCode_q == $past(ioWrData[1:0]))
    else $error("rate select write did not set rate");

  AST_LOW_POWER_SET: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrRate && ioWrData[DSR_LOWPWR_BIT] |=> ctrlClockStop)
    else $error("low power not entered");

  AST_SW_RESET_KEEP: assert property (@(posedge ref_clk) disable iff (!resetn)
    ctrlSoftReset && !wrRate && !wrCcr |=> $stable(rateCode_q) && $stable(writeCodeA_q))
    else $error("soft reset changed rate select");

  AST_WRITE_CODE_A_ZERO: assert property (@(posedge ref_clk) disable iff (!resetn)
    writeCodeA_q == PRE_ZERO |=> writePrecompUnits == 4'h0)
    else $error("zero write_code_a code gave a delay");

endmodule : frsr_regs
`default_nettype wire

// ===== pkg/frsr_pkg.sv
// constants and types for the floppy rate and status registers
package frsr_pkg;
  // host port addresses
  localparam logic [15:0] ADDR_DOR = 16'h03F2;
  localparam logic [15:0] ADDR_TAPE = 16'h03F3;
  localparam logic [15:0] ADDR_RATE_STAT = 16'h03F4;
  localparam logic [15:0] ADDR_DATA = 16'h03F5;
  localparam logic [15:0] ADDR_CCR = 16'h03F7;
  // rate select register fields
  localparam int DSR_RATE_LSB = 0;
  localparam int DSR_PRE_LSB = 2;
  localparam int DSR_RSVD_BIT = 5;
  localparam int DSR_LOWPWR_BIT = 6;
  localparam int DSR_SWRST_BIT = 7;
  localparam logic [7:0] DSR_RESET = 8'h02;
  // tape drive register fields
  localparam int TDR_MEDIA1_BIT = 7;
  localparam int TDR_MEDIA0_BIT = 6;
  localparam int TDR_TYPE_LSB = 4;
  localparam int TDR_BOOT_LSB = 2;
  localparam logic [1:0] TAPE_RESET = 2'h0;
  // config f1 field positions
  localparam int F1_BOOT_HI = 7;
  localparam int F1_BOOT_LO = 6;
  localparam int F1_INV1 = 5;
  localparam int F1_INV0 = 4;
  // precompensation codes and delays in 1/48 MHz units
  localparam logic [2:0] PRE_DEFAULT = 3'h0;
  localparam logic [2:0] PRE_ZERO = 3'h7;
  localparam logic [3:0] PRE_DEF_2M = 4'h1;
  localparam logic [3:0] PRE_DEF_1M = 4'h2;
  localparam logic [3:0] PRE_DEF_LOW = 4'h6;
  // software reset stretch
  localparam int CLK_PERIOD_NS = 10;
  localparam int SW_RESET_MIN_NS = 100;
  localparam int SW_RESET_CYC_I = (SW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SW_RESET_CYCLES = 4'(SW_RESET_CYC_I);
  // data rates
  typedef enum logic [2:0] {
    RATE_250 = 3'b000,
    RATE_300 = 3'b001,
    RATE_500 = 3'b010,
    RATE_1M = 3'b011,
    RATE_2M = 3'b100
  } frsr_rate_type;
endpackage : frsr_pkg

// ===== test/frsr_host_model.sv
// host processor model driving the register io port
`timescale 1ns/10ps
`default_nettype none
module frsr_host_model
  import frsr_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // io port
  output logic [15:0] ioAddr,
  output logic ioRdStrobe,
  output logic ioWrStrobe,
  output logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData
);
  // idle bus at time zero
  initial begin
    ioAddr = 16'h0000;
    ioRdStrobe = 1'b0;
    ioWrStrobe = 1'b0;
    ioWrData = 8'h00;
  end
  // one write, strobe held over one rising edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    ioAddr = a;
    ioWrData = (a == ADDR_RATE_STAT) ? (d & 8'hDF) : d;
    ioWrStrobe = 1'b1;
    @(negedge ref_clk);
    ioWrStrobe = 1'b0;
    ioWrData = ~ioWrData; // released data does not stay stale
    @(negedge ref_clk);
  endtask : wr
  // one read, data taken once the answer has landed
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    ioAddr = a;
    ioRdStrobe = 1'b1;
    @(negedge ref_clk);
    ioRdStrobe = 1'b0;
    @(negedge ref_clk);
    d = ioRdData;
  endtask : rd
  // data byte read only after status grants it
  task automatic data_rd(output logic ok);
    logic [7:0] st;
    rd(ADDR_RATE_STAT, st);
    ok = st[7];
    if (st[7] === 1'b1) rd(ADDR_DATA, st);
  endtask : data_rd
endmodule : frsr_host_model
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the floppy rate and status registers
`timescale 1ns/10ps
`default_nettype none
module testbench
  import frsr_pkg::*;
;
  logic ref_clk, resetn, ioRdStrobe, ioWrStrobe, enhancedMode2, dorSoftResetN, cmdBusy, polledExecFlag;
  logic transferDirection, requestForMaster, fmMode, ctrlSoftReset, ctrlClockStop, densitySelect;
  logic dataRegGrant, precompEnable, ok;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData, ioRdData, floppyConfigF1, floppyConfigF2, currentTrack, precompStartTrack, dsrShadow, v;
  logic [1:0] driveRateType, driveSelect, mediaIdentPins, rateCode, driveDensityPins;
  logic [3:0] driveSeekBusy, writePrecompUnits;
  logic [11:0] dataRateKbps;
  frsr_rate_type rateSel;
  int err_total = 0;
  int checked = 0;
  int swCnt = 0;
  frsr_host_model host (.ref_clk(ref_clk), .ioAddr(ioAddr), .ioRdStrobe(ioRdStrobe), .ioWrStrobe(ioWrStrobe),
    .ioWrData(ioWrData), .ioRdData(ioRdData));
  frsr_regs dut (.ref_clk(ref_clk), .resetn(resetn), .ioAddr(ioAddr), .ioRdStrobe(ioRdStrobe),
    .ioWrStrobe(ioWrStrobe), .ioWrData(ioWrData), .ioRdData(ioRdData), .enhancedMode2(enhancedMode2),
    .floppyConfigF1(floppyConfigF1), .floppyConfigF2(floppyConfigF2), .driveRateType(driveRateType),
    .driveSelect(driveSelect), .dorSoftResetN(dorSoftResetN), .mediaIdentPins(mediaIdentPins),
    .driveSeekBusy(driveSeekBusy), .cmdBusy(cmdBusy), .polledExecFlag(polledExecFlag),
    .transferDirection(transferDirection), .requestForMaster(requestForMaster), .fmMode(fmMode),
    .currentTrack(currentTrack), .precompStartTrack(precompStartTrack), .ctrlSoftReset(ctrlSoftReset),
    .ctrlClockStop(ctrlClockStop), .rateCode(rateCode), .rateSel(rateSel), .dataRateKbps(dataRateKbps),
    .densitySelect(densitySelect), .driveDensityPins(driveDensityPins), .writePrecompUnits(writePrecompUnits),
    .precompEnable(precompEnable), .dsrShadow(dsrShadow), .dataRegGrant(dataRegGrant));
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // soft reset pulse length counter
  always @(negedge ref_clk) begin
    if (ctrlSoftReset === 1'b1) swCnt <= swCnt + 1;
  end
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // verdict and end of run
  task automatic summarize();
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // expected rate in kbps
  function automatic logic [11:0] expKbps(input logic [1:0] t, input logic [1:0] c, input logic f);
    logic [11:0] k;
    case (c)
      2'h3: k = 12'h3E8;
      2'h0: k = 12'h1F4;
      2'h1: k = (t == 2'h1) ? 12'h1F4 : ((t == 2'h2) ? 12'h7D0 : 12'h12C);
      default: k = 12'h0FA;
    endcase
    if (f && k < 12'h3E8) k = k >> 1; // fm halves the low rates
    return k;
  endfunction : expKbps
  // expected drive density pins
  function automatic logic [1:0] expPins(input logic [1:0] dt, input logic [1:0] c);
    logic den;
    den = (c == 2'h3) || (c == 2'h0);
    case (dt)
      2'h0: return {c[0], den};
      2'h2: return {c[0], c[1]};
      2'h1: return {c[0], ~den};
      default: return {c[1], c[0]};
    endcase
  endfunction : expPins
  // values after hardware reset
  task automatic t_reset();
    chk(dsrShadow, 8'h02);
    chk(dataRateKbps, 12'h0FA);
    chk(writePrecompUnits, 4'h6);
    chk(ctrlClockStop, 1'h0);
  endtask : t_reset
  // every rate code for drive rate types 0 to 2, mfm and fm
  task automatic t_rates();
    for (int t = 0; t < 3; t++) for (int f = 0; f < 2; f++) for (int c = 0; c < 4; c++) begin
      driveRateType = 2'(t);
      fmMode = 1'(f);
      host.wr(ADDR_RATE_STAT, 8'(c));
      chk(dataRateKbps, expKbps(2'(t), 2'(c), 1'(f)));
      chk(rateSel == RATE_2M, (t == 2 && c == 1));
      chk(densitySelect, (c == 3 || c == 0));
    end
    fmMode = 1'b0;
    driveRateType = 2'h0;
  endtask : t_rates
  // last writer of either rate address wins
  task automatic t_ccr();
    host.wr(ADDR_RATE_STAT, 8'h00);
    host.wr(ADDR_CCR, 8'h03);
    chk(rateCode, 2'h3);
    host.wr(ADDR_RATE_STAT, 8'h01);
    chk(rateCode, 2'h1);
  endtask : t_ccr
  // precompensation steps, defaults and start track
  task automatic t_write_code_a();
    for (int p = 1; p < 8; p++) begin
      host.wr(ADDR_RATE_STAT, 8'(p * 4 + 2));
      chk(writePrecompUnits, (p == 7) ? 4'h0 : 4'(2 * p));
    end
    host.wr(ADDR_RATE_STAT, 8'h03);
    chk(writePrecompUnits, PRE_DEF_1M);
    driveRateType = 2'h2;
    host.wr(ADDR_RATE_STAT, 8'h01);
    chk(writePrecompUnits, PRE_DEF_2M);
    host.wr(ADDR_RATE_STAT, 8'h0D);
    chk(writePrecompUnits, 4'h3);
    driveRateType = 2'h0;
    currentTrack = 8'h05;
    precompStartTrack = 8'h06;
    @(negedge ref_clk);
    chk(precompEnable, 1'h0);
    precompStartTrack = 8'h05;
    @(negedge ref_clk);
    chk(precompEnable, 1'h1);
  endtask : t_write_code_a
  // enhanced tape register view, density pins, resets
  task automatic t_tape();
    logic [7:0] f1;
    enhancedMode2 = 1'b1;
    floppyConfigF2 = 8'hE4;
    mediaIdentPins = 2'h1;
    host.wr(ADDR_RATE_STAT, 8'h01);
    host.wr(ADDR_TAPE, 8'h02);
    for (int k = 0; k < 8; k++) begin
      f1 = (k < 4) ? 8'hA0 : 8'h5F;
      floppyConfigF1 = f1;
      driveSelect = 2'(k);
      host.rd(ADDR_TAPE, v);
      chk(v, {mediaIdentPins ^ f1[5:4], floppyConfigF2[2 * (k % 4) +: 2], f1[7:6], 2'h2});
      chk(driveDensityPins, expPins(floppyConfigF2[2 * (k % 4) +: 2], 2'h1));
    end
    enhancedMode2 = 1'b0;
    host.rd(ADDR_TAPE, v);
    chk(v, 8'h02);
    host.rd(ADDR_DOR, v);
    chk(v, 8'h00);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    chk(dsrShadow, 8'h02);
    enhancedMode2 = 1'b1;
    host.rd(ADDR_TAPE, v);
    chk(v[7:6], mediaIdentPins ^ floppyConfigF1[5:4]);
  endtask : t_tape
  // low power entry and exits, live main status
  task automatic t_status();
    host.wr(ADDR_RATE_STAT, 8'h42);
    chk(ctrlClockStop, 1'h1);
    {driveSeekBusy, cmdBusy, polledExecFlag, transferDirection, requestForMaster} = 8'h5F;
    host.rd(ADDR_RATE_STAT, v);
    chk(v, 8'hF5);
    chk(ctrlClockStop, 1'h0);
    host.wr(ADDR_RATE_STAT, 8'h42);
    host.rd(ADDR_DATA, v);
    chk(ctrlClockStop, 1'h0);
    host.wr(ADDR_RATE_STAT, 8'h42);
    host.data_rd(ok);
    chk(ok, 1'h1);
    chk(ctrlClockStop, 1'h0);
    {driveSeekBusy, cmdBusy, polledExecFlag, transferDirection, requestForMaster} = 8'hA0;
    host.rd(ADDR_RATE_STAT, v);
    chk(v, 8'h0A);
    chk(dataRegGrant, 1'h0);
    {cmdBusy, polledExecFlag, transferDirection, requestForMaster} = 4'hD;
    host.rd(ADDR_RATE_STAT, v);
    chk(v[7:4], 4'hB);
  endtask : t_status
  // self clearing soft reset from the rate register, held soft reset from the output register
  task automatic t_swrst();
    int i;
    host.wr(ADDR_RATE_STAT, 8'hC1);
    for (i = 0; i < 40 && ctrlSoftReset !== 1'b0; i++) @(negedge ref_clk);
    if (i == 40) begin
      err_total++;
      summarize();
    end
    chk(16'(swCnt), 16'(SW_RESET_CYCLES));
    chk(rateCode, 2'h1);
    chk(dsrShadow[4:0], 5'h01);
    chk(ctrlClockStop, 1'h0);
    dorSoftResetN = 1'b0;
    @(negedge ref_clk);
    chk(ctrlSoftReset, 1'h1);
    dorSoftResetN = 1'b1;
  endtask : t_swrst
  // main sequence
  initial begin
    resetn = 1'b0;
    {enhancedMode2, floppyConfigF1, floppyConfigF2, driveRateType, driveSelect} = 21'h0;
    {dorSoftResetN, mediaIdentPins, driveSeekBusy, cmdBusy, polledExecFlag} = 9'h100;
    {transferDirection, requestForMaster, fmMode, currentTrack, precompStartTrack} = 19'h0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    t_reset();
    t_rates();
    t_ccr();
    t_write_code_a();
    t_tape();
    t_status();
    t_swrst();
    summarize();
  end
endmodule : testbench
`default_nettype wire
